// >>> design/ssr_pkg.sv
package ssr_pkg;

    // ==========================================================================
    // Sizes
    // ==========================================================================
    localparam int NUM_RELAYS   = 4;
    localparam int NUM_DELAYED  = 3;
    localparam int NUM_SHUTDOWN = 3;
    localparam int TIME_W       = 16;
    localparam int TIME_FRAC    = 8;
    localparam int CNT_W        = 24;
    localparam int STAT_W       = 3;
    localparam int IDX_W        = 3;

    // ==========================================================================
    // Timing
    // ==========================================================================
    // Times are unsigned seconds with eight fraction bits.
    localparam longint            US_PER_S          = 1_000_000;
    localparam int                CTRL_CYCLE_US_DEF = 10_000;
    localparam logic [TIME_W-1:0] LIMIT_MAX_S       = 16'h0100;
    localparam logic [CNT_W-1:0]  CNT_ONE           = 24'h00_0001;
    localparam logic [CNT_W-1:0]  CNT_MAX           = 24'hFF_FFFF;

    // ==========================================================================
    // Indices and status codes
    // ==========================================================================
    localparam logic [IDX_W-1:0]  INDEX_MIN      = 3'h1;
    localparam logic [IDX_W-1:0]  INDEX_MAX      = 3'h4;
    localparam logic [STAT_W-1:0] POS_OK         = 3'h0;
    localparam logic [STAT_W-1:0] POS_INDEX      = 3'h1;
    localparam logic [STAT_W-1:0] POS_FIRST      = 3'h3;
    localparam logic [STAT_W-1:0] POS_TEST_ACK   = 3'h4;
    localparam logic [STAT_W-1:0] POS_SHUTDOWN_1 = 3'h5;
    localparam logic [STAT_W-1:0] POS_OPT        = 3'h4;
    localparam int                EVAL_IN_BIT    = 0;
    localparam int                EVAL_OUT_BIT   = 1;
    localparam int                EVAL_TIME_BIT  = 2;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {SSR_CMD_INPUTS, SSR_CMD_OUTPUTS, SSR_CMD_TIMES} ssr_cmd_t;
    typedef enum logic [1:0] {SSR_IDLE, SSR_ON, SSR_TRIPPED} ssr_state_t;

    typedef struct packed {
        logic                    real_ack;
        logic                    test_ack;
        logic [NUM_SHUTDOWN-1:0] shutdown;
    } ssr_relay_sig_t;

    typedef struct packed {
        logic                   direct;
        logic [NUM_DELAYED-1:0] delayed;
    } ssr_out_map_t;

    typedef struct packed {
        logic                                limit;
        logic [NUM_DELAYED-1:0]              delay;
        logic [TIME_W-1:0]                   limit_time;
        logic [NUM_DELAYED-1:0][TIME_W-1:0]  delay_time;
    } ssr_time_cfg_t;

    typedef struct packed {
        ssr_cmd_t          cmd;
        logic [IDX_W-1:0]  index;
        ssr_relay_sig_t    in_map;
        ssr_out_map_t      out_map;
        ssr_time_cfg_t     times;
    } ssr_cfg_t;

    // ==========================================================================
    // Functions
    // ==========================================================================
    function automatic logic [CNT_W-1:0] ssr_secs_to_cycles(input logic [TIME_W-1:0] secs,
                                                            input int cycle_us);
        longint prod;
        prod = (longint'(secs) * US_PER_S) >>> TIME_FRAC;
        return CNT_W'(prod / longint'(cycle_us));
    endfunction

    function automatic logic ssr_and(input logic [NUM_SHUTDOWN-1:0] level,
                                     input logic [NUM_SHUTDOWN-1:0] used);
        return &(level | ~used);
    endfunction

endpackage

// >>> design/ssr_relay.sv
module ssr_relay
    import ssr_pkg::*;
#(
    parameter int CTRL_CYCLE_US = CTRL_CYCLE_US_DEF
) (
    input  logic                                       CLOCK_IN,
    input  logic                                       RSTN_IN,
    input  logic                                       CLK_EN_IN,
    input  logic                                       CYCLE_TICK_IN,
    input  logic                                       CFG_VALID_IN,
    input  ssr_cfg_t                                   CFG_IN,
    output logic [STAT_W-1:0]                          CFG_STATUS_OUT,
    output logic                                       CFG_DONE_OUT,
    input  ssr_relay_sig_t [NUM_RELAYS-1:0]            RELAY_IN,
    input  logic [NUM_RELAYS-1:0]                      INIT_PASS_FLAG_IN,
    output logic [NUM_RELAYS-1:0]                      INIT_PASS_CLR_OUT,
    output logic [NUM_RELAYS-1:0]                      DIRECT_OUT,
    output logic [NUM_RELAYS-1:0][NUM_DELAYED-1:0]     DELAYED_OUT,
    output logic [NUM_RELAYS-1:0][NUM_DELAYED-1:0]     DELAYED_EN_OUT,
    output logic [NUM_RELAYS-1:0][STAT_W-1:0]          EVAL_STATUS_OUT
);

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);

    // ==========================================================================
    // Configuration store
    // ==========================================================================
    logic                   cfg_we;
    logic [1:0]             cfg_idx;
    logic [STAT_W-1:0]      cfg_status_d;
    logic [STAT_W-1:0]      cfg_status_q;
    logic                   cfg_done_q;
    logic [NUM_RELAYS-1:0]  in_ok_q;
    logic [NUM_RELAYS-1:0]  out_ok_q;
    logic [NUM_RELAYS-1:0]  time_ok_q;
    ssr_relay_sig_t         in_map_q   [NUM_RELAYS];
    ssr_out_map_t           out_map_q  [NUM_RELAYS];
    logic [NUM_DELAYED-1:0] time_map_q [NUM_RELAYS];
    logic [CNT_W-1:0]       limit_cyc_q [NUM_RELAYS];
    logic [NUM_DELAYED-1:0][CNT_W-1:0] dly_cyc_q [NUM_RELAYS];

    assign cfg_we  = CLK_EN_IN && CFG_VALID_IN;
    assign cfg_idx = 2'(CFG_IN.index - INDEX_MIN);

    // The optional-pair check is made by whichever of outputs and times comes second.
    always_comb begin
        cfg_status_d = POS_OK;
        if (CFG_IN.index < INDEX_MIN || CFG_IN.index > INDEX_MAX) begin
            cfg_status_d = POS_INDEX;
        end else begin
            case (CFG_IN.cmd)
                SSR_CMD_INPUTS: begin
                    if (!CFG_IN.in_map.real_ack) begin
                        cfg_status_d = POS_FIRST;
                    end else if (!CFG_IN.in_map.test_ack) begin
                        cfg_status_d = POS_TEST_ACK;
                    end else if (!CFG_IN.in_map.shutdown[0]) begin
                        cfg_status_d = POS_SHUTDOWN_1;
                    end
                end
                SSR_CMD_OUTPUTS: begin
                    if (!CFG_IN.out_map.direct) begin
                        cfg_status_d = POS_FIRST;
                    end else begin
                        for (int k = NUM_DELAYED - 1; k >= 0; k--) begin
                            if (time_ok_q[cfg_idx] &&
                                CFG_IN.out_map.delayed[k] != time_map_q[cfg_idx][k]) begin
                                cfg_status_d = POS_OPT + STAT_W'(k);
                            end
                        end
                    end
                end
                SSR_CMD_TIMES: begin
                    if (!CFG_IN.times.limit || CFG_IN.times.limit_time > LIMIT_MAX_S) begin
                        cfg_status_d = POS_FIRST;
                    end else begin
                        for (int k = NUM_DELAYED - 1; k >= 0; k--) begin
                            if (out_ok_q[cfg_idx] &&
                                CFG_IN.times.delay[k] != out_map_q[cfg_idx].delayed[k]) begin
                                cfg_status_d = POS_OPT + STAT_W'(k);
                            end
                        end
                    end
                end
                default: cfg_status_d = POS_INDEX;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cfg_status_q <= POS_OK;
            cfg_done_q   <= '0;
            in_ok_q      <= '0;
            out_ok_q     <= '0;
            time_ok_q    <= '0;
            for (int i = 0; i < NUM_RELAYS; i++) begin
                in_map_q[i]    <= '0;
                out_map_q[i]   <= '0;
                time_map_q[i]  <= '0;
                limit_cyc_q[i] <= '0;
                dly_cyc_q[i]   <= '0;
            end
        end else if (CLK_EN_IN) begin
            cfg_done_q <= CFG_VALID_IN;
            if (cfg_we) begin
                cfg_status_q <= cfg_status_d;
            end
            if (cfg_we && cfg_status_d != POS_INDEX) begin
                case (CFG_IN.cmd)
                    SSR_CMD_INPUTS: begin
                        in_ok_q[cfg_idx]  <= (cfg_status_d == POS_OK);
                        in_map_q[cfg_idx] <= CFG_IN.in_map;
                    end
                    SSR_CMD_OUTPUTS: begin
                        out_ok_q[cfg_idx]  <= (cfg_status_d == POS_OK);
                        out_map_q[cfg_idx] <= CFG_IN.out_map;
                    end
                    SSR_CMD_TIMES: begin
                        time_ok_q[cfg_idx]   <= (cfg_status_d == POS_OK);
                        time_map_q[cfg_idx]  <= CFG_IN.times.delay;
                        limit_cyc_q[cfg_idx] <= ssr_secs_to_cycles(CFG_IN.times.limit_time,
                                                                   CTRL_CYCLE_US);
                        for (int k = 0; k < NUM_DELAYED; k++) begin
                            dly_cyc_q[cfg_idx][k] <= ssr_secs_to_cycles(
                                CFG_IN.times.delay_time[k], CTRL_CYCLE_US);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    assign CFG_STATUS_OUT = cfg_status_q;
    assign CFG_DONE_OUT   = cfg_done_q;

    // ==========================================================================
    // Cyclic evaluation
    // ==========================================================================
    logic                  ev;
    logic [NUM_RELAYS-1:0] run_ok;
    logic [NUM_RELAYS-1:0] sd_now;
    logic [NUM_RELAYS-1:0] sd_prev_q;
    logic [NUM_RELAYS-1:0] test_ok;
    logic [NUM_RELAYS-1:0] direct_q;
    logic [NUM_RELAYS-1:0] init_clr_q;
    ssr_state_t            state_q [NUM_RELAYS];
    ssr_state_t            state_d [NUM_RELAYS];
    logic [CNT_W-1:0]      low_q   [NUM_RELAYS];
    logic [CNT_W-1:0]      peak_q  [NUM_RELAYS];
    logic [NUM_DELAYED-1:0][CNT_W-1:0] dcnt_q [NUM_RELAYS];
    logic [NUM_RELAYS-1:0][NUM_DELAYED-1:0] dly_out_q;

    assign ev = CLK_EN_IN && CYCLE_TICK_IN;

    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            run_ok[i] = in_ok_q[i] && out_ok_q[i] && time_ok_q[i];
            sd_now[i] = ssr_and(RELAY_IN[i].shutdown, in_map_q[i].shutdown);
            // A long shutdown leaves the peak at or above the limit, so only a real ack helps.
            test_ok[i] = sd_now[i] && RELAY_IN[i].test_ack &&
                         (peak_q[i] < limit_cyc_q[i]);
            EVAL_STATUS_OUT[i] = '0;
            EVAL_STATUS_OUT[i][EVAL_IN_BIT]   = !in_ok_q[i];
            EVAL_STATUS_OUT[i][EVAL_OUT_BIT]  = !out_ok_q[i];
            EVAL_STATUS_OUT[i][EVAL_TIME_BIT] = !time_ok_q[i];
            state_d[i] = state_q[i];
            if (INIT_PASS_FLAG_IN[i]) begin
                state_d[i] = SSR_IDLE;
            end else if (run_ok[i]) begin
                case (state_q[i])
                    SSR_IDLE: begin
                        if (sd_now[i] && RELAY_IN[i].real_ack) begin
                            state_d[i] = SSR_ON;
                        end
                    end
                    SSR_ON: begin
                        if (!sd_now[i]) begin
                            state_d[i] = SSR_TRIPPED;
                        end
                    end
                    SSR_TRIPPED: begin
                        if (sd_now[i] && (RELAY_IN[i].real_ack || test_ok[i])) begin
                            state_d[i] = SSR_ON;
                        end
                    end
                    default: state_d[i] = SSR_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            direct_q   <= '0;
            sd_prev_q  <= '0;
            init_clr_q <= '0;
            for (int i = 0; i < NUM_RELAYS; i++) begin
                state_q[i] <= SSR_IDLE;
            end
        end else if (CLK_EN_IN) begin
            init_clr_q <= ev ? INIT_PASS_FLAG_IN : '0;
            if (ev) begin
                sd_prev_q <= sd_now;
                for (int i = 0; i < NUM_RELAYS; i++) begin
                    state_q[i]  <= state_d[i];
                    direct_q[i] <= (state_d[i] == SSR_ON);
                end
            end
        end
    end

    // Low time t4 and its running peak since the last trip from an energised relay.
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < NUM_RELAYS; i++) begin
                low_q[i]  <= '0;
                peak_q[i] <= '0;
            end
        end else if (ev) begin
            for (int i = 0; i < NUM_RELAYS; i++) begin
                if (INIT_PASS_FLAG_IN[i]) begin
                    low_q[i]  <= '0;
                    peak_q[i] <= '0;
                end else if (run_ok[i] && !sd_now[i]) begin
                    if (sd_prev_q[i]) begin
                        low_q[i] <= CNT_ONE;
                        if (direct_q[i] || peak_q[i] < CNT_ONE) begin
                            peak_q[i] <= CNT_ONE;
                        end
                    end else if (low_q[i] != CNT_MAX) begin
                        low_q[i] <= low_q[i] + CNT_ONE;
                        if (low_q[i] >= peak_q[i]) begin
                            peak_q[i] <= low_q[i] + CNT_ONE;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            dly_out_q <= '0;
            for (int i = 0; i < NUM_RELAYS; i++) begin
                dcnt_q[i] <= '0;
            end
        end else if (ev) begin
            for (int i = 0; i < NUM_RELAYS; i++) begin
                for (int k = 0; k < NUM_DELAYED; k++) begin
                    if (INIT_PASS_FLAG_IN[i] || !out_map_q[i].delayed[k]) begin
                        dly_out_q[i][k] <= '0;
                        dcnt_q[i][k]    <= '0;
                    end else if (state_d[i] == SSR_ON) begin
                        dly_out_q[i][k] <= '1;
                        dcnt_q[i][k]    <= dly_cyc_q[i][k];
                    end else if (dcnt_q[i][k] == '0) begin
                        dly_out_q[i][k] <= '0;
                    end else begin
                        dcnt_q[i][k] <= dcnt_q[i][k] - CNT_ONE;
                    end
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            DELAYED_EN_OUT[i] = out_map_q[i].delayed;
        end
    end

    assign DIRECT_OUT        = direct_q;
    assign DELAYED_OUT       = dly_out_q;
    assign INIT_PASS_CLR_OUT = init_clr_q;

    // ==========================================================================
    // Checks on relay 1
    // ==========================================================================
    a_direct_needs_and: assert property (DIRECT_OUT[0] |-> sd_prev_q[0])
        else $error("direct output high while shutdown AND was low");
    a_unused_high: assert property (ev && run_ok[0] && !INIT_PASS_FLAG_IN[0] &&
        state_q[0] == SSR_ON && RELAY_IN[0].shutdown[0] &&
        in_map_q[0].shutdown[2:1] == 2'h0 |=> DIRECT_OUT[0])
        else $error("unconnected shutdown input did not read high");
    a_delay_rise: assert property ($rose(DIRECT_OUT[0]) && DELAYED_EN_OUT[0][0]
        |-> DELAYED_OUT[0][0])
        else $error("delayed output did not follow rising direct output");
    a_delay_hold: assert property ($fell(DIRECT_OUT[0]) && dly_cyc_q[0][0] != '0 &&
        !$past(INIT_PASS_FLAG_IN[0]) && DELAYED_EN_OUT[0][0] |-> DELAYED_OUT[0][0])
        else $error("delayed output fell before its delay");
    a_runup_quiet: assert property (state_q[0] == SSR_IDLE
        |-> !DIRECT_OUT[0] && DELAYED_OUT[0] == '0)
        else $error("output active before real acknowledge");
    a_test_ack_window: assert property (ev && state_q[0] == SSR_TRIPPED &&
        !RELAY_IN[0].real_ack && peak_q[0] >= limit_cyc_q[0] |=> state_q[0] != SSR_ON)
        else $error("test acknowledge cleared a long shutdown");
    a_cfg_bad_index: assert property (cfg_we &&
        (CFG_IN.index < INDEX_MIN || CFG_IN.index > INDEX_MAX)
        |=> CFG_DONE_OUT && CFG_STATUS_OUT == POS_INDEX)
        else $error("bad relay index not reported");
    a_cfg_mismatch: assert property (cfg_we && CFG_IN.index == INDEX_MIN &&
        CFG_IN.cmd == SSR_CMD_OUTPUTS && CFG_IN.out_map.direct && time_ok_q[0] &&
        CFG_IN.out_map.delayed[0] != time_map_q[0][0] |=> CFG_STATUS_OUT == POS_OPT)
        else $error("output without delay not flagged");
    a_eval_code: assert property (CFG_DONE_OUT && CFG_STATUS_OUT != POS_OK &&
        $past(CFG_IN.cmd) == SSR_CMD_INPUTS && $past(CFG_IN.index) == INDEX_MIN
        |-> EVAL_STATUS_OUT[0][EVAL_IN_BIT])
        else $error("bad input assignment not shown in evaluation code");
    a_undriven: assert property (!DELAYED_EN_OUT[0][1] |-> !DELAYED_OUT[0][1])
        else $error("unassigned delayed output driven");
    a_first_pass: assert property (ev |=> INIT_PASS_CLR_OUT[0] == $past(INIT_PASS_FLAG_IN[0]) &&
        (!$past(INIT_PASS_FLAG_IN[0]) || !DIRECT_OUT[0]))
        else $error("first pass not cleared or outputs not reset");

    c_trip: cover property (state_q[0] == SSR_ON ##1 state_q[0] == SSR_TRIPPED);
    c_test_ack: cover property (ev && state_q[0] == SSR_TRIPPED && test_ok[0] &&
        !RELAY_IN[0].real_ack ##1 state_q[0] == SSR_ON);
    c_delay_drop: cover property (!DIRECT_OUT[0] && $fell(DELAYED_OUT[0][0]));

endmodule

// >>> verification/safety_software_relay_test.sv
module safety_software_relay_test
    import ssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CYC = 100;
    logic                  CLOCK_IN = 1'b0;
    logic                  RSTN_IN = 1'b0;
    logic                  cfg_valid = 1'b0;
    logic                  rearm = 1'b0;
    ssr_cfg_t              cfg_q = '0;
    logic [3:0][2:0]       level = '1;
    logic [3:0]            button = '0;
    logic [3:0]            marker = '0;
    logic [3:0]            flag, clr, direct;
    logic [3:0][2:0]       dly, dly_en, eval;
    logic [2:0]            status;
    logic                  done;
    ssr_relay_sig_t [3:0]  relay;
    int                    n_errors = 0;
    int                    compares = 0;

    initial forever #50 CLOCK_IN = ~CLOCK_IN;

    ssr_relay #(.CTRL_CYCLE_US(CYC)) i_dut (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN),
        .CLK_EN_IN(1'b1), .CYCLE_TICK_IN(1'b1), .CFG_VALID_IN(cfg_valid), .CFG_IN(cfg_q),
        .CFG_STATUS_OUT(status), .CFG_DONE_OUT(done), .RELAY_IN(relay),
        .INIT_PASS_FLAG_IN(flag), .INIT_PASS_CLR_OUT(clr), .DIRECT_OUT(direct),
        .DELAYED_OUT(dly), .DELAYED_EN_OUT(dly_en), .EVAL_STATUS_OUT(eval));

    ssr_far_side i_far (.clk_in(CLOCK_IN), .rst_n_in(RSTN_IN), .rearm_in(rearm),
        .clr_in(clr), .level_in(level), .button_in(button), .marker_in(marker),
        .flag_out(flag), .relay_out(relay));

    // =========================================================================
    // Tasks
    // =========================================================================
    task automatic step(input int n);
        repeat (n) @(posedge CLOCK_IN);
        #10;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The answer is fixed at one cycle, so no wait loop is needed here.
    task automatic cfg(input ssr_cmd_t c, input logic [2:0] idx, input ssr_relay_sig_t im,
                       input ssr_time_cfg_t tm, input logic [2:0] exp);
        cfg_q.cmd = c;
        cfg_q.index = idx;
        cfg_q.in_map = im;
        cfg_q.out_map = '{direct: 1'b1, delayed: tm.delay};
        cfg_q.times = tm;
        cfg_valid = 1'b1;
        step(1);
        cfg_valid = 1'b0;
        chk(8'(done), 8'h01, "config done");
        chk(8'(status), 8'(exp), "config status");
        step(1);
        chk(8'(done), 8'h00, "config done drops");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // =========================================================================
    // Sequence
    // =========================================================================
    initial begin
        int             first[3];
        int             lim;
        ssr_relay_sig_t im;
        ssr_time_cfg_t  good, tm;
        im = '{real_ack: 1'b1, test_ack: 1'b1, shutdown: 3'b001};
        good = '{limit: 1'b1, delay: 3'b111, limit_time: 16'h0001,
                 delay_time: {16'h0003, 16'h0002, 16'h0001}};
        lim = int'((longint'(1) * 1000000 / 256) / CYC);
        step(8);
        chk(8'(eval[0]), 8'h07, "status in reset");
        chk(8'(direct), 8'h00, "direct in reset");
        RSTN_IN = 1'b1;
        step(3);
        chk(8'(flag), 8'h00, "first pass cleared");
        cfg(SSR_CMD_INPUTS, 3'h5, im, good, 3'h1);
        cfg(SSR_CMD_INPUTS, 3'h1, '{1'b1, 1'b0, 3'b001}, good, 3'h4);
        cfg(SSR_CMD_INPUTS, 3'h1, im, good, 3'h0);
        cfg(SSR_CMD_OUTPUTS, 3'h1, im, good, 3'h0);
        tm = good;
        tm.limit_time = 16'h0101;
        cfg(SSR_CMD_TIMES, 3'h1, im, tm, 3'h3);
        tm = good;
        tm.delay = 3'b011;
        cfg(SSR_CMD_TIMES, 3'h1, im, tm, 3'h6);
        cfg(SSR_CMD_TIMES, 3'h1, im, good, 3'h0);
        tm.delay = 3'b110;
        cfg(SSR_CMD_OUTPUTS, 3'h1, im, tm, 3'h4);
        cfg(SSR_CMD_OUTPUTS, 3'h1, im, good, 3'h0);
        cfg(SSR_CMD_INPUTS, 3'h2, im, good, 3'h0);
        chk(8'(eval[0]), 8'h00, "relay one status");
        chk(8'(eval[1]), 8'h06, "relay two status");
        chk(8'(dly_en[0]), 8'h07, "assigned outputs");
        chk(8'(dly_en[1]), 8'h00, "unassigned outputs");
        $display("configuration test finished");
        step(3);
        chk(8'(direct), 8'h00, "held before acknowledge");
        button[0] = 1'b1;
        step(1);
        button[0] = 1'b0;
        chk(8'(direct), 8'h01, "on after acknowledge");
        chk(8'(dly[0]), 8'h07, "delayed rise");
        level[0][2:1] = 2'b00;
        step(2);
        chk(8'(direct), 8'h01, "unused inputs high");
        level[0][0] = 1'b0;
        step(1);
        chk(8'(direct), 8'h00, "direct drop");
        first = '{-1, -1, -1};
        for (int i = 1; i <= 130; i++) begin
            step(1);
            for (int k = 0; k < 3; k++) if (dly[0][k] === 1'b0 && first[k] < 0) first[k] = i;
        end
        for (int k = 0; k < 3; k++) chk(8'(first[k]), 8'(((k + 1) * 1000000 / 256) / CYC),
                                        "delayed fall");
        $display("output timing test finished");
        level[0][0] = 1'b1;
        marker[0] = 1'b1;
        step(2);
        marker[0] = 1'b0;
        chk(8'(direct), 8'h00, "real shutdown kept");
        for (int len = lim; len >= lim - 1; len--) begin
            button[0] = 1'b1;
            step(1);
            button[0] = 1'b0;
            chk(8'(direct), 8'h01, "acknowledged");
            level[0][0] = 1'b0;
            step(len);
            level[0][0] = 1'b1;
            marker[0] = 1'b1;
            step(1);
            marker[0] = 1'b0;
            chk(8'(direct), 8'(len < lim), "test acknowledge window");
        end
        $display("test acknowledge test finished");
        rearm = 1'b1;
        step(1);
        rearm = 1'b0;
        step(2);
        chk(8'(direct), 8'h00, "first pass forces off");
        chk(8'(flag), 8'h00, "first pass cleared again");
        $display("first pass test finished");
        results();
    end
endmodule

// >>> verification/ssr_far_side.sv
// =============================================================================
// Safety program side: retained first-pass flags, pushbuttons and markers.
// =============================================================================
module ssr_far_side
    import ssr_pkg::*;
(
    input  wire logic                                     clk_in,
    input  wire logic                                     rst_n_in,
    input  wire logic                                     rearm_in,
    input  wire logic [NUM_RELAYS-1:0]                    clr_in,
    input  wire logic [NUM_RELAYS-1:0][NUM_SHUTDOWN-1:0]  level_in,
    input  wire logic [NUM_RELAYS-1:0]                    button_in,
    input  wire logic [NUM_RELAYS-1:0]                    marker_in,
    output logic      [NUM_RELAYS-1:0]                    flag_out,
    output ssr_relay_sig_t [NUM_RELAYS-1:0]               relay_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [NUM_RELAYS-1:0] flag_q;

    // One retained flag per relay, so a clear of one never touches another.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_q <= '1;
        end else if (rearm_in) begin
            flag_q <= '1;
        end else begin
            flag_q <= flag_q & ~clr_in;
        end
    end

    assign flag_out = flag_q;

    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            relay_out[i].real_ack = button_in[i];
            relay_out[i].test_ack = marker_in[i];
            relay_out[i].shutdown = level_in[i];
        end
    end
endmodule
